// ==== dppa_core.sv ====
// Register and control core of the dual parallel port adapter
//
// Operation
// R01 - Reset clears every host register (arming bits are set): all lines inputs, all interrupts disabled.
// R02 - Six host locations: data, direction and control for each side.
// R03 - Select 01 control A, 11 control B, 00/10 shared A/B by bit 2.
// R04 - Direction-access bit 1 routes shared address to peripheral data register.
// R05 - Direction-access bit 0 routes shared address to direction register.
// R06 - Port A data read returns pin level for output lines.
// R07 - Port B data read returns output latch for output lines.
// R08 - Control bits 0 to 5 are host readable and writable.
// R09 - Control bits 6 and 7 are read-only flags set by line events.
// R10 - Flags set by active edges on control lines configured as inputs.
// R11 - Writes never set flags; reading side data register clears them.
// R12 - Control bit 5 low makes second line an interrupt input.
// R13 - Control bit 5 high drives second line as an output.
// R14 - Control bit 0 enables that side's interrupt request output; code gates only flag 7 with it, flag 6 with bit 3.
// R15 - Control bit 1 selects active edge of first control line.
// R16 - Direction bit 1 drives line from output register; 0 makes input.
// R17 - Open-drain active-low request asserts while an enabled flag is set.
// R18 - Cleared flag not settable until an enable pulse while deselected.
// R19 - Host selects with both positive selects high, negative low, stable.
// R20 - Edge select 1 means rising edge, 0 means falling edge.
// R21 - Control writes change bits 0 to 5 only, keeping flags.
`timescale 1ns/10ps
module dppa_core
	import dppa_pkg::*;
(
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	// Host bus
	input wire logic i_enable,
	input wire logic i_read,
	input wire logic i_chip_select_pos0,
	input wire logic i_chip_select_pos1,
	input wire logic i_chip_select_neg_n,
	input wire logic i_select_high_bit,
	input wire logic i_select_low_bit,
	input wire logic [7:0] i_data,
	output logic [7:0] o_data,
	output logic o_data_oe,
	// Port lines
	input wire logic [7:0] i_port_a_lines,
	output logic [7:0] o_port_a_lines,
	output logic [7:0] o_port_a_lines_oe,
	input wire logic [7:0] i_port_b_lines,
	output logic [7:0] o_port_b_lines,
	output logic [7:0] o_port_b_lines_oe,
	// Control lines
	input wire logic i_side_a_first_control_line,
	input wire logic i_side_a_second_control_line,
	output logic o_side_a_second_control_line,
	output logic o_side_a_second_control_line_oe,
	input wire logic i_side_b_first_control_line,
	input wire logic i_side_b_second_control_line,
	output logic o_side_b_second_control_line,
	output logic o_side_b_second_control_line_oe,
	// Open-drain interrupt requests (output always low, enable drives)
	output logic o_side_a_irq_out_n,
	output logic o_side_a_irq_out_n_oe,
	output logic o_side_b_irq_out_n,
	output logic o_side_b_irq_out_n_oe
);

	// ==========================================
	// State
	dppa_side_t a_reg, a_next, b_reg, b_next;
	logic en_d_reg, en_d_next;
	logic [3:0] line_d_reg, line_d_next;
	logic [3:0] arm_reg, arm_next;
	logic [7:0] rd_reg, rd_next;
	logic rd_oe_reg, rd_oe_next;
	logic [1:0] irq_reg, irq_next;
	logic [1:0] l2_reg, l2_next;
	// Low for the first cycle after reset so idle-high lines give no false edge
	logic edge_ok_reg, edge_ok_next;

	dppa_host_t host;
	logic selected, e_rise, e_fall, acc, wr;
	logic [1:0] sel;
	logic [3:0] line_now, rise, fall, act, input_mode;
	logic [7:0] a_read_val, b_read_val;
	logic clr_a, clr_b;

	always_comb begin
		host = '{cs_pos0: i_chip_select_pos0, cs_pos1: i_chip_select_pos1,
			cs_neg_n: i_chip_select_neg_n, sel_high: i_select_high_bit,
			sel_low: i_select_low_bit, read: i_read, wdata: i_data};
	end

	// ==========================================
	// Bus decode
	assign selected = host.cs_pos0 & host.cs_pos1 & ~host.cs_neg_n; // [R19]
	assign e_rise = i_enable & ~en_d_reg;
	assign e_fall = ~i_enable & en_d_reg;
	assign sel = {host.sel_high, host.sel_low};
	// Writes land on the falling edge of enable; reads are answered on its rise
	assign acc = e_fall & selected;
	assign wr = acc & ~host.read;

	// Port A reads the pin, port B reads the latch for output lines
	assign a_read_val = i_port_a_lines; // [R06]
	assign b_read_val = (b_reg.out_reg & b_reg.dir_reg) | (i_port_b_lines & ~b_reg.dir_reg); // [R07]

	// Reading the data register of a side clears its flags
	assign clr_a = acc & host.read & (sel == DPPA_SEL_SHARED_A) & a_reg.ctrl_reg[DPPA_DIR_ACCESS]; // [R11]
	assign clr_b = acc & host.read & (sel == DPPA_SEL_SHARED_B) & b_reg.ctrl_reg[DPPA_DIR_ACCESS]; // [R11]

	// ==========================================
	// Edge sense: {b2, b1, a2, a1}
	assign line_now = {i_side_b_second_control_line, i_side_b_first_control_line,
		i_side_a_second_control_line, i_side_a_first_control_line};
	assign rise = line_now & ~line_d_reg & {4{edge_ok_reg}};
	assign fall = ~line_now & line_d_reg & {4{edge_ok_reg}};
	// Second lines use the same edge choice as their first line
	assign act[0] = a_reg.ctrl_reg[DPPA_EDGE_SELECT] ? rise[0] : fall[0]; // [R15] [R20]
	assign act[1] = a_reg.ctrl_reg[DPPA_EDGE_SELECT] ? rise[1] : fall[1]; // [R12]
	assign act[2] = b_reg.ctrl_reg[DPPA_EDGE_SELECT] ? rise[2] : fall[2]; // [R15] [R20]
	assign act[3] = b_reg.ctrl_reg[DPPA_EDGE_SELECT] ? rise[3] : fall[3]; // [R12]
	assign input_mode = {~b_reg.ctrl_reg[DPPA_LINE2_OUT], 1'b1, ~a_reg.ctrl_reg[DPPA_LINE2_OUT], 1'b1}; // [R10] [R12]

	always_comb begin
		a_next = a_reg;
		b_next = b_reg;
		en_d_next = i_enable;
		line_d_next = line_now;
		edge_ok_next = 1'b1;
		arm_next = arm_reg;
		rd_next = rd_reg;
		rd_oe_next = rd_oe_reg;
		// Register writes
		if (wr) begin
			case (sel) // [R02] [R03]
				DPPA_SEL_SHARED_A: begin
					if (a_reg.ctrl_reg[DPPA_DIR_ACCESS]) begin
						a_next.out_reg = host.wdata; // [R04]
					end else begin
						a_next.dir_reg = host.wdata; // [R05]
					end
				end
				DPPA_SEL_SHARED_B: begin
					if (b_reg.ctrl_reg[DPPA_DIR_ACCESS]) begin
						b_next.out_reg = host.wdata; // [R04]
					end else begin
						b_next.dir_reg = host.wdata; // [R05]
					end
				end
				DPPA_SEL_CTRL_A: begin
					a_next.ctrl_reg = (a_reg.ctrl_reg & ~DPPA_CTRL_WMASK) | (host.wdata & DPPA_CTRL_WMASK); // [R08] [R21]
				end
				DPPA_SEL_CTRL_B: begin
					b_next.ctrl_reg = (b_reg.ctrl_reg & ~DPPA_CTRL_WMASK) | (host.wdata & DPPA_CTRL_WMASK); // [R08] [R21]
				end
				default: begin
				end
			endcase
		end
		// Flag clears, then re-arm on a deselected enable pulse
		if (clr_a) begin
			a_next.ctrl_reg[DPPA_FLAG1] = DPPA_RESET_BIT; // [R11]
			a_next.ctrl_reg[DPPA_FLAG2] = DPPA_RESET_BIT;
			arm_next[1:0] = 2'h0; // [R18]
		end
		if (clr_b) begin
			b_next.ctrl_reg[DPPA_FLAG1] = DPPA_RESET_BIT; // [R11]
			b_next.ctrl_reg[DPPA_FLAG2] = DPPA_RESET_BIT;
			arm_next[3:2] = 2'h0; // [R18]
		end
		if (e_fall && !selected) begin
			arm_next = 4'hf; // [R18]
		end
		// Flag sets win over a clear in the same cycle
		if (act[0] && input_mode[0] && arm_reg[0]) begin
			a_next.ctrl_reg[DPPA_FLAG1] = 1'b1; // [R09] [R10]
		end
		if (act[1] && input_mode[1] && arm_reg[1]) begin
			a_next.ctrl_reg[DPPA_FLAG2] = 1'b1; // [R10] [R12]
		end
		if (act[2] && input_mode[2] && arm_reg[2]) begin
			b_next.ctrl_reg[DPPA_FLAG1] = 1'b1; // [R09] [R10]
		end
		if (act[3] && input_mode[3] && arm_reg[3]) begin
			b_next.ctrl_reg[DPPA_FLAG2] = 1'b1; // [R10] [R12]
		end
		// Read data, captured at the rise of enable and held until its fall
		if (e_rise && selected && host.read) begin
			rd_oe_next = 1'b1;
			case (sel) // [R03]
				DPPA_SEL_SHARED_A: rd_next = a_reg.ctrl_reg[DPPA_DIR_ACCESS] ? a_read_val : a_reg.dir_reg; // [R04] [R05]
				DPPA_SEL_SHARED_B: rd_next = b_reg.ctrl_reg[DPPA_DIR_ACCESS] ? b_read_val : b_reg.dir_reg; // [R04] [R05]
				DPPA_SEL_CTRL_A: rd_next = a_reg.ctrl_reg; // [R08] [R09]
				DPPA_SEL_CTRL_B: rd_next = b_reg.ctrl_reg;
				default: rd_next = DPPA_RESET_BYTE;
			endcase
		end else if (e_fall || !i_enable) begin
			rd_oe_next = 1'b0;
		end
	end

	// ==========================================
	// Interrupt requests and second control line outputs
	always_comb begin
		irq_next[0] = (a_reg.ctrl_reg[DPPA_FLAG1] & a_reg.ctrl_reg[DPPA_IRQ_ENABLE])
			| (a_reg.ctrl_reg[DPPA_FLAG2] & a_reg.ctrl_reg[DPPA_LINE2_B3] & ~a_reg.ctrl_reg[DPPA_LINE2_OUT]); // [R14] [R17]
		irq_next[1] = (b_reg.ctrl_reg[DPPA_FLAG1] & b_reg.ctrl_reg[DPPA_IRQ_ENABLE])
			| (b_reg.ctrl_reg[DPPA_FLAG2] & b_reg.ctrl_reg[DPPA_LINE2_B3] & ~b_reg.ctrl_reg[DPPA_LINE2_OUT]); // [R14] [R17]
		// Output mode: level given by bit 3 when bit 4 is set
		l2_next[0] = a_reg.ctrl_reg[DPPA_LINE2_B4] & a_reg.ctrl_reg[DPPA_LINE2_B3]; // [R13]
		l2_next[1] = b_reg.ctrl_reg[DPPA_LINE2_B4] & b_reg.ctrl_reg[DPPA_LINE2_B3]; // [R13]
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			a_reg <= '0; // [R01]
			b_reg <= '0; // [R01]
			en_d_reg <= DPPA_RESET_BIT;
			line_d_reg <= 4'h0;
			edge_ok_reg <= DPPA_RESET_BIT;
			arm_reg <= 4'hf;
			rd_reg <= DPPA_RESET_BYTE;
			rd_oe_reg <= DPPA_RESET_BIT;
			irq_reg <= 2'h0;
			l2_reg <= 2'h0;
		end else begin
			a_reg <= a_next;
			b_reg <= b_next;
			en_d_reg <= en_d_next;
			line_d_reg <= line_d_next;
			edge_ok_reg <= edge_ok_next;
			arm_reg <= arm_next;
			rd_reg <= rd_next;
			rd_oe_reg <= rd_oe_next;
			irq_reg <= irq_next;
			l2_reg <= l2_next;
		end
	end

	// ==========================================
	// Pin drive, all from flip-flops except the constant-low request levels
	assign o_data = rd_reg;
	assign o_data_oe = rd_oe_reg;
	assign o_port_a_lines = a_reg.out_reg; // [R16]
	assign o_port_a_lines_oe = a_reg.dir_reg; // [R16]
	assign o_port_b_lines = b_reg.out_reg;
	assign o_port_b_lines_oe = b_reg.dir_reg; // [R16]
	assign o_side_a_second_control_line = l2_reg[0];
	assign o_side_a_second_control_line_oe = a_reg.ctrl_reg[DPPA_LINE2_OUT]; // [R13]
	assign o_side_b_second_control_line = l2_reg[1];
	assign o_side_b_second_control_line_oe = b_reg.ctrl_reg[DPPA_LINE2_OUT]; // [R13]
	assign o_side_a_irq_out_n = DPPA_RESET_BIT; // [R17]
	assign o_side_a_irq_out_n_oe = irq_reg[0];
	assign o_side_b_irq_out_n = DPPA_RESET_BIT;
	assign o_side_b_irq_out_n_oe = irq_reg[1];

endmodule : dppa_core

// ==== dppa_pkg.sv ====
// Package of constants and carrier types for the dual parallel port adapter
package dppa_pkg;

	localparam int DPPA_W = 8;

	// ==========================================
	// Register select codes {select_high_bit, select_low_bit}
	localparam logic [1:0] DPPA_SEL_SHARED_A = 2'h0;
	localparam logic [1:0] DPPA_SEL_CTRL_A = 2'h1;
	localparam logic [1:0] DPPA_SEL_SHARED_B = 2'h2;
	localparam logic [1:0] DPPA_SEL_CTRL_B = 2'h3;

	// ==========================================
	// Control register field positions
	localparam int DPPA_IRQ_ENABLE = 0;
	localparam int DPPA_EDGE_SELECT = 1;
	localparam int DPPA_DIR_ACCESS = 2;
	localparam int DPPA_LINE2_B3 = 3;
	localparam int DPPA_LINE2_B4 = 4;
	localparam int DPPA_LINE2_OUT = 5;
	localparam int DPPA_FLAG2 = 6;
	localparam int DPPA_FLAG1 = 7;
	localparam logic [7:0] DPPA_CTRL_WMASK = 8'h3f;

	// ==========================================
	// Reset values
	localparam logic [7:0] DPPA_RESET_BYTE = 8'h00;
	localparam logic DPPA_RESET_BIT = 1'b0;

	// Host bus request, sampled at the rise of enable for reads and just after its fall for writes
	typedef struct packed {
		logic cs_pos0;
		logic cs_pos1;
		logic cs_neg_n;
		logic sel_high;
		logic sel_low;
		logic read;
		logic [7:0] wdata;
	} dppa_host_t;

	// One port side: output latch, direction and control registers
	typedef struct packed {
		logic [7:0] out_reg;
		logic [7:0] dir_reg;
		logic [7:0] ctrl_reg;
	} dppa_side_t;

endpackage : dppa_pkg

// ==== dppa_core_properties.sv ====
// Port timing checks for the adapter core
`timescale 1ns/10ps
module dppa_core_properties
	import dppa_pkg::*;
(
	// Clock, reset and host bus
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic i_enable,
	input wire logic i_read,
	input wire logic i_chip_select_pos0,
	input wire logic i_chip_select_pos1,
	input wire logic i_chip_select_neg_n,
	input wire logic o_data_oe,
	// Pins
	input wire logic [7:0] o_port_a_lines,
	input wire logic [7:0] o_port_b_lines_oe,
	input wire logic o_side_a_irq_out_n,
	input wire logic o_side_a_irq_out_n_oe
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);
	wire sel = i_chip_select_pos0 & i_chip_select_pos1 & ~i_chip_select_neg_n;
	// ==========================================
	// Assertions
	read_answer_a: assert property ($rose(i_enable) && sel && i_read |=> o_data_oe)
		else $error("read not answered");
	no_drive_a: assert property ($rose(i_enable) && !(sel && i_read) |=> !o_data_oe)
		else $error("bus driven without selected read");
	release_a: assert property (!i_enable |=> !o_data_oe)
		else $error("bus not released");
	hold_a: assert property (o_data_oe && i_enable |=> o_data_oe)
		else $error("bus dropped early");
	irq_const_a: assert property (o_side_a_irq_out_n == 1'b0)
		else $error("request pin level not low");
	irq_release_a: assert property ($fell(o_side_a_irq_out_n_oe) |-> $past(i_enable, 3) || $past(i_enable, 4))
		else $error("request released without host access");
	dir_change_a: assert property (!$stable(o_port_b_lines_oe) |-> !$past(i_enable) && $past(i_enable, 2))
		else $error("direction changed without write");
	out_change_a: assert property (!$stable(o_port_a_lines) |-> !$past(i_enable) && $past(i_enable, 2))
		else $error("output changed without write");
	cover property ($rose(o_side_a_irq_out_n_oe));
	cover property ($rose(o_data_oe));
	cover property (!$stable(o_port_b_lines_oe));
endmodule : dppa_core_properties

bind dppa_core dppa_core_properties u_props (.*);

// ==== dppa_host_model.sv ====
// Host bus master model for the adapter core
`timescale 1ns/10ps
module dppa_host_model
	import dppa_pkg::*;
#(
	parameter int HOLD = 2
)(
	// Clock and read data
	input wire logic i_ref_clk,
	input wire logic [7:0] i_data,
	// Host bus
	output dppa_host_t o_req,
	output logic o_enable
);
	initial begin
		o_req = '0;
		o_enable = 1'b0;
	end
	// ==========================================
	// One bus cycle: selects and data stay put around the whole strobe
	task automatic acc(input logic [1:0] s, input logic rd, input logic [7:0] wd, input logic on,
			output logic [7:0] q);
		@(posedge i_ref_clk);
		o_req <= '{on, 1'b1, 1'b0, s[1], s[0], rd, wd};
		@(posedge i_ref_clk);
		o_enable <= 1'b1;
		repeat (HOLD) @(posedge i_ref_clk);
		q = i_data;
		o_enable <= 1'b0;
		repeat (2) @(posedge i_ref_clk);
		o_req <= '{1'b0, 1'b1, 1'b0, ~s[1], ~s[0], ~rd, ~wd};
	endtask : acc
endmodule : dppa_host_model

// ==== dppa_core_test.sv ====
// Self-checking bench for the adapter core
`timescale 1ns/10ps
module dppa_core_test;
	import dppa_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] pa = 8'h33, pb = 8'h00, rdata, q, o_pa, o_pa_oe, o_pb, o_pb_oe;
	logic [3:0] cl = 4'hf;
	logic en, a2_oe, b2, b2_oe, side_a_irq_out_n_oe, side_b_irq_out_n_oe;
	dppa_host_t req;
	int mismatches = 0;
	int n_compared = 0;
	int cyc = 0;
	always #12.5 clk = ~clk;
	dppa_host_model #(.HOLD(3)) u_dppa_host_model (.i_ref_clk(clk), .i_data(rdata), .o_req(req), .o_enable(en));
	dppa_core u_dppa_core (
		.i_ref_clk(clk), .i_reset_n(rst_n), .i_enable(en), .i_read(req.read),
		.i_chip_select_pos0(req.cs_pos0), .i_chip_select_pos1(req.cs_pos1),
		.i_chip_select_neg_n(req.cs_neg_n), .i_select_high_bit(req.sel_high),
		.i_select_low_bit(req.sel_low), .i_data(req.wdata), .o_data(rdata), .o_data_oe(),
		.i_port_a_lines(pa), .o_port_a_lines(o_pa), .o_port_a_lines_oe(o_pa_oe),
		.i_port_b_lines(pb), .o_port_b_lines(o_pb), .o_port_b_lines_oe(o_pb_oe),
		.i_side_a_first_control_line(cl[3]), .i_side_a_second_control_line(cl[2]),
		.o_side_a_second_control_line(), .o_side_a_second_control_line_oe(a2_oe),
		.i_side_b_first_control_line(cl[1]), .i_side_b_second_control_line(cl[0]),
		.o_side_b_second_control_line(b2), .o_side_b_second_control_line_oe(b2_oe),
		.o_side_a_irq_out_n(), .o_side_a_irq_out_n_oe(side_a_irq_out_n_oe),
		.o_side_b_irq_out_n(), .o_side_b_irq_out_n_oe(side_b_irq_out_n_oe)
	);
	// ==========================================
	// Tasks
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [1:0] s, input logic [7:0] d);
		u_dppa_host_model.acc(s, 1'b0, d, 1'b1, q);
	endtask : wr
	task automatic rd(input logic [1:0] s, input logic [7:0] exp);
		u_dppa_host_model.acc(s, 1'b1, 8'h00, 1'b1, q);
		chk(q, exp);
	endtask : rd
	task automatic idle_pulse;
		u_dppa_host_model.acc(DPPA_SEL_CTRL_A, 1'b0, 8'h00, 1'b0, q);
	endtask : idle_pulse
	task automatic lines(input logic [3:0] v);
		@(posedge clk);
		cl <= v;
		repeat (4) @(posedge clk);
	endtask : lines
	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			mismatches++;
			close_out();
		end
	end
	// ==========================================
	// Main sequence
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		rd(DPPA_SEL_CTRL_A, 8'h00);
		rd(DPPA_SEL_SHARED_B, 8'h00);
		wr(DPPA_SEL_SHARED_A, 8'hf0);
		wr(DPPA_SEL_SHARED_B, 8'h0f);
		wr(DPPA_SEL_CTRL_A, 8'hc5);
		rd(DPPA_SEL_CTRL_A, 8'h05);
		wr(DPPA_SEL_CTRL_B, 8'h3e);
		rd(DPPA_SEL_CTRL_B, 8'h3e);
		wr(DPPA_SEL_SHARED_A, 8'h5a);
		wr(DPPA_SEL_SHARED_B, 8'ha5);
		chk(o_pa_oe, 8'hf0);
		chk(o_pa, 8'h5a);
		chk(o_pb_oe, 8'h0f);
		chk(o_pb, 8'ha5);
		chk({5'h00, a2_oe, b2_oe, b2}, 8'h03);
		rd(DPPA_SEL_SHARED_A, 8'h33);
		rd(DPPA_SEL_SHARED_B, 8'h05);
		idle_pulse();
		rd(DPPA_SEL_CTRL_A, 8'h05);
		lines(4'h0);
		rd(DPPA_SEL_CTRL_A, 8'hc5);
		rd(DPPA_SEL_CTRL_B, 8'h3e);
		chk({7'h00, side_a_irq_out_n_oe}, 8'h01);
		rd(DPPA_SEL_SHARED_A, 8'h33);
		rd(DPPA_SEL_CTRL_A, 8'h05);
		chk({7'h00, side_a_irq_out_n_oe}, 8'h00);
		lines(4'hf);
		lines(4'h0);
		rd(DPPA_SEL_CTRL_A, 8'h05);
		idle_pulse();
		lines(4'hf);
		lines(4'h0);
		rd(DPPA_SEL_CTRL_A, 8'hc5);
		rd(DPPA_SEL_CTRL_B, 8'hbe);
		chk({7'h00, side_b_irq_out_n_oe}, 8'h00);
		close_out();
	end
endmodule : dppa_core_test
